// [rtl/config_pin_mode_select_consts.vh]
`ifndef CONFIG_PIN_MODE_SELECT_CONSTS_VH
`define CONFIG_PIN_MODE_SELECT_CONSTS_VH

// Decoded three-level pin states
`define TL_LOW 2'h0
`define TL_HIGH 2'h1
`define TL_FLOAT 2'h2

// Positions of the three-level pins in the decoded level bus
`define PIN_EQA 0
`define PIN_EQB 1
`define PIN_EQD 2
`define PIN_PORT_A_TX_DEEMPH_SEL 3
`define PIN_PORT_B_TX_DEEMPH_SEL 4
`define PIN_PORT_D_TX_DEEMPH_SEL 5
`define PIN_RATE 6
`define PIN_COUNT 7

// Shared pins reused in register mode
`define PIN_SDA `PIN_EQB
`define PIN_SCL `PIN_PORT_B_TX_DEEMPH_SEL
`define PIN_AD0 `PIN_EQA
`define PIN_AD1 `PIN_PORT_A_TX_DEEMPH_SEL
`define PIN_AD2 `PIN_EQD
`define PIN_AD3 `PIN_PORT_D_TX_DEEMPH_SEL

// Lane layout and field widths
`define LANES 6
`define EQ_W 4
`define DEM_W 3

// Pin-mode setting codes
`define EQ_PIN_LOW 4'h1
`define EQ_PIN_FLOAT 4'h4
`define EQ_PIN_HIGH 4'h8
`define DEM_PIN_LOW 3'h0
`define DEM_PIN_FLOAT 3'h2
`define DEM_PIN_HIGH 3'h5

// Rate selections
`define RATE_3G 2'h0
`define RATE_6G 2'h1
`define RATE_AUTO 2'h2
`define RATE_FOLLOW 2'h3

// SMBus register indices and reset values
`define REG_EQ_BASE 0
`define REG_DEM_BASE 6
`define REG_VOD 12
`define REG_RATE 13
`define REG_PD 14
`define REG_IDLE 15
`define SMB_REG_COUNT 16
`define EQ_REG_RST 8'h04
`define DEM_REG_RST 8'h02
`define VOD_REG_RST 8'h00
`define VOD_OUT_RST 2'h0
`define RATE_REG_RST 8'h03
`define PD_REG_RST 8'h00
`define IDLE_TH_DEFAULT 8'h82
`define SMB_BITS 4'h8
`define SMB_ADDR_HI_RST 3'h5

// SMBus slave states
`define ST_IDLE 4'h0
`define ST_ADDR 4'h1
`define ST_ADDR_ACK 4'h2
`define ST_CMD 4'h3
`define ST_CMD_ACK 4'h4
`define ST_WDATA 4'h5
`define ST_WDATA_ACK 4'h6
`define ST_RDATA 4'h7
`define ST_RDATA_ACK 4'h8
`define ST_RDATA_NEXT 4'h9

// APB register byte addresses
`define APB_STATUS 8'h00
`define APB_CTRL 8'h04
`define APB_EQ 8'h08
`define APB_DEM 8'h0c
`define APB_ADDR 8'h10
`define APB_MISC 8'h14

`endif

// [rtl/bit_sync.v]
`timescale 1ns/1ps
module bit_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // Two-stage synchroniser, first stage read only by the second
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [rtl/tri_level_decoder.v]
`timescale 1ns/1ps
`include "config_pin_mode_select_consts.vh"
module tri_level_decoder (
  input wire core_clk,
  input wire sys_rst,
  input wire sense_hi,
  input wire sense_lo,
  output reg [1:0] level
);

  reg [1:0] meta;
  reg [1:0] stable;

  // Synchronise both comparator senses, then classify
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 2'h0;
      stable <= 2'h0;
      level <= `TL_FLOAT;
    end else begin
      meta <= {sense_hi, sense_lo};
      stable <= meta;
      case (stable)
        2'h2: level <= `TL_HIGH;
        2'h1: level <= `TL_LOW;
        default: level <= `TL_FLOAT;
      endcase
    end
  end

endmodule

// [rtl/config_pin_mode_select.v]
`timescale 1ns/1ps
`include "config_pin_mode_select_consts.vh"
// Function
// - Strap high: SMBus host reaches eq, de-emphasis, swing, rate, power-down, idle registers.
// - Strap low: SMBus access blocked; settings come from control pins.
// - Strap high enables the bidirectional SMBus data pin and clock input.
// - Register mode: four strapped inputs form the low four slave address bits, the APB CTRL register the upper three; answer only that.
// - Pin mode: each eq pin decoded three-level to pick group equalization.
// - Eq pins govern port A inputs, port B inputs, D-side inputs.
// - Eq pins ignored unless the strap is low.
// - Strap high: per-lane SMBus registers replace shared eq pin settings.
// - Pin mode: each de-emphasis pin decoded three-level for its output group.
// - De-emphasis pins govern port A, port B, D-side outputs.
// - De-emphasis pins honoured only in pin mode; registers give per-lane control.
// - Rate pin decoded in pin mode, and in register mode while the rate register holds 3: low 3G, high 6G, float auto.
// - Three-level inputs recognise high, low and an undriven mid float state.
module config_pin_mode_select (
  input wire core_clk,
  input wire sys_rst,
  input wire register_mode_strap,
  input wire port_a_rx_eq_sel_hi,
  input wire port_a_rx_eq_sel_lo,
  input wire port_b_rx_eq_sel_hi,
  input wire port_b_rx_eq_sel_lo,
  input wire port_d_rx_eq_sel_hi,
  input wire port_d_rx_eq_sel_lo,
  input wire port_a_tx_deemph_sel_hi,
  input wire port_a_tx_deemph_sel_lo,
  input wire port_b_tx_deemph_sel_hi,
  input wire port_b_tx_deemph_sel_lo,
  input wire port_d_tx_deemph_sel_hi,
  input wire port_d_tx_deemph_sel_lo,
  input wire rate_sel_hi,
  input wire rate_sel_lo,
  input wire [1:0] vod_sel,
  output wire smb_data_out,
  output wire smb_data_oe_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  output wire [23:0] lane_rx_eq,
  output wire [17:0] lane_tx_deemph,
  output reg [1:0] out_vod,
  output reg [1:0] rate_mode,
  output reg [5:0] lane_power_down,
  output reg [7:0] idle_threshold,
  output wire register_mode
);

  integer i;

  wire [2:0] strap_sync;
  wire [1:0] vod_pin;
  wire [13:0] lvl_bus;
  wire [6:0] sense_hi;
  wire [6:0] sense_lo;
  wire scl;
  wire sda;
  wire [6:0] slave_addr;
  wire scl_rise;
  wire scl_fall;
  wire smb_start;
  wire smb_stop;
  wire smb_busy;

  reg [2:0] addr_hi;
  reg [3:0] smb_state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [3:0] ptr;
  reg rw;
  reg sda_drive;
  reg scl_d;
  reg sda_d;
  reg [7:0] smb_regs [0:15];

  // Level of a decoded pin as a plain logic one
  function is_one;
    input [1:0] code;
    begin
      is_one = (code == `TL_HIGH);
    end
  endfunction

  // Group equalization code from a three-level pin
  function [3:0] eq_from_pin;
    input [1:0] code;
    begin
      case (code)
        `TL_LOW: eq_from_pin = `EQ_PIN_LOW;
        `TL_HIGH: eq_from_pin = `EQ_PIN_HIGH;
        default: eq_from_pin = `EQ_PIN_FLOAT;
      endcase
    end
  endfunction

  // Group de-emphasis code from a three-level pin
  function [2:0] dem_from_pin;
    input [1:0] code;
    begin
      case (code)
        `TL_LOW: dem_from_pin = `DEM_PIN_LOW;
        `TL_HIGH: dem_from_pin = `DEM_PIN_HIGH;
        default: dem_from_pin = `DEM_PIN_FLOAT;
      endcase
    end
  endfunction

  // Reset value of each SMBus register
  function [7:0] reg_default;
    input [3:0] idx;
    begin
      if (idx < `REG_DEM_BASE)
        reg_default = `EQ_REG_RST;
      else if (idx < `REG_VOD)
        reg_default = `DEM_REG_RST;
      else if (idx == `REG_VOD)
        reg_default = `VOD_REG_RST;
      else if (idx == `REG_RATE)
        reg_default = `RATE_REG_RST;
      else if (idx == `REG_PD)
        reg_default = `PD_REG_RST;
      else
        reg_default = `IDLE_TH_DEFAULT;
    end
  endfunction

  // Strap and swing pins into the core clock
  bit_sync #(
    .WIDTH(3)
  ) u_strap_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({vod_sel, register_mode_strap}),
    .sync_out(strap_sync)
  );

  assign register_mode = strap_sync[0];
  assign vod_pin = strap_sync[2:1];

  // Comparator senses in level-bus order
  assign sense_hi = {rate_sel_hi, port_d_tx_deemph_sel_hi, port_b_tx_deemph_sel_hi,
                     port_a_tx_deemph_sel_hi, port_d_rx_eq_sel_hi, port_b_rx_eq_sel_hi,
                     port_a_rx_eq_sel_hi};
  assign sense_lo = {rate_sel_lo, port_d_tx_deemph_sel_lo, port_b_tx_deemph_sel_lo,
                     port_a_tx_deemph_sel_lo, port_d_rx_eq_sel_lo, port_b_rx_eq_sel_lo,
                     port_a_rx_eq_sel_lo};

  // One decoder per three-level pin
  genvar p;
  generate
    for (p = 0; p < `PIN_COUNT; p = p + 1) begin : g_pin
      tri_level_decoder u_dec (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sense_hi(sense_hi[p]),
        .sense_lo(sense_lo[p]),
        .level(lvl_bus[2*p+1:2*p])
      );
    end
  endgenerate

  // Shared pins seen as SMBus wires and address straps
  assign scl = is_one(lvl_bus[2*`PIN_SCL+1:2*`PIN_SCL]);
  assign sda = is_one(lvl_bus[2*`PIN_SDA+1:2*`PIN_SDA]);
  assign slave_addr = {addr_hi,
                       is_one(lvl_bus[2*`PIN_AD3+1:2*`PIN_AD3]),
                       is_one(lvl_bus[2*`PIN_AD2+1:2*`PIN_AD2]),
                       is_one(lvl_bus[2*`PIN_AD1+1:2*`PIN_AD1]),
                       is_one(lvl_bus[2*`PIN_AD0+1:2*`PIN_AD0])};

  // Bus edge and condition detection
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign smb_start = scl & scl_d & sda_d & ~sda;
  assign smb_stop = scl & scl_d & ~sda_d & sda;
  assign smb_busy = (smb_state != `ST_IDLE);

  // Open-drain data pin, driven only while pulling low
  assign smb_data_out = 1'b0;
  assign smb_data_oe_n = ~sda_drive;

  // SMBus slave: address, pointer, write and read bytes
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smb_state <= `ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 4'h0;
      rw <= 1'b0;
      sda_drive <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      for (i = 0; i < `SMB_REG_COUNT; i = i + 1) begin
        smb_regs[i] <= reg_default(i[3:0]);
      end
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (!register_mode) begin
        smb_state <= `ST_IDLE;
        sda_drive <= 1'b0;
      end else if (smb_start) begin
        smb_state <= `ST_ADDR;
        bit_cnt <= 4'h0;
        sda_drive <= 1'b0;
      end else if (smb_stop) begin
        smb_state <= `ST_IDLE;
        sda_drive <= 1'b0;
      end else begin
        case (smb_state)
          `ST_ADDR, `ST_CMD, `ST_WDATA: begin
            if (scl_rise && bit_cnt != `SMB_BITS) begin
              shift <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `SMB_BITS) begin
              bit_cnt <= 4'h0;
              if (smb_state == `ST_ADDR) begin
                if (shift[7:1] == slave_addr) begin
                  sda_drive <= 1'b1;
                  rw <= shift[0];
                  smb_state <= `ST_ADDR_ACK;
                end else begin
                  smb_state <= `ST_IDLE;
                end
              end else if (smb_state == `ST_CMD) begin
                ptr <= shift[3:0];
                sda_drive <= 1'b1;
                smb_state <= `ST_CMD_ACK;
              end else begin
                smb_regs[ptr] <= shift;
                ptr <= ptr + 4'h1;
                sda_drive <= 1'b1;
                smb_state <= `ST_WDATA_ACK;
              end
            end
          end
          `ST_ADDR_ACK, `ST_CMD_ACK, `ST_WDATA_ACK: begin
            if (scl_fall) begin
              if (smb_state == `ST_ADDR_ACK && rw) begin
                shift <= smb_regs[ptr];
                sda_drive <= ~smb_regs[ptr][7];
                bit_cnt <= 4'h1;
                smb_state <= `ST_RDATA;
              end else begin
                sda_drive <= 1'b0;
                bit_cnt <= 4'h0;
                if (smb_state == `ST_ADDR_ACK)
                  smb_state <= `ST_CMD;
                else
                  smb_state <= `ST_WDATA;
              end
            end
          end
          `ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == `SMB_BITS) begin
                sda_drive <= 1'b0;
                smb_state <= `ST_RDATA_ACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                sda_drive <= ~shift[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          `ST_RDATA_ACK: begin
            if (scl_rise) begin
              if (sda) begin
                smb_state <= `ST_IDLE;
              end else begin
                ptr <= ptr + 4'h1;
                smb_state <= `ST_RDATA_NEXT;
              end
            end
          end
          `ST_RDATA_NEXT: begin
            if (scl_fall) begin
              shift <= smb_regs[ptr];
              sda_drive <= ~smb_regs[ptr][7];
              bit_cnt <= 4'h1;
              smb_state <= `ST_RDATA;
            end
          end
          default: begin
            smb_state <= `ST_IDLE;
            sda_drive <= 1'b0;
          end
        endcase
      end
    end
  end

  // Per-lane equalization and de-emphasis selection
  genvar l;
  generate
    for (l = 0; l < `LANES; l = l + 1) begin : g_lane
      localparam integer EQ_IDX = `REG_EQ_BASE + l;
      localparam integer DEM_IDX = `REG_DEM_BASE + l;
      localparam integer EQ_PIN = `PIN_EQA + l / 2;
      localparam integer DEM_PIN = `PIN_PORT_A_TX_DEEMPH_SEL + l / 2;
      reg [3:0] eq_q;
      reg [2:0] dem_q;
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          eq_q <= `EQ_PIN_FLOAT;
          dem_q <= `DEM_PIN_FLOAT;
        end else if (register_mode) begin
          eq_q <= smb_regs[EQ_IDX][3:0];
          dem_q <= smb_regs[DEM_IDX][2:0];
        end else begin
          eq_q <= eq_from_pin(lvl_bus[2*EQ_PIN+1:2*EQ_PIN]);
          dem_q <= dem_from_pin(lvl_bus[2*DEM_PIN+1:2*DEM_PIN]);
        end
      end
      assign lane_rx_eq[`EQ_W*l+`EQ_W-1:`EQ_W*l] = eq_q;
      assign lane_tx_deemph[`DEM_W*l+`DEM_W-1:`DEM_W*l] = dem_q;
    end
  endgenerate

  // Swing, rate, power-down and idle threshold
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_vod <= `VOD_OUT_RST;
      rate_mode <= `RATE_AUTO;
      lane_power_down <= 6'h00;
      idle_threshold <= `IDLE_TH_DEFAULT;
    end else begin
      if (register_mode && smb_regs[`REG_RATE][1:0] != `RATE_FOLLOW) begin
        rate_mode <= smb_regs[`REG_RATE][1:0];
      end else begin
        case (lvl_bus[2*`PIN_RATE+1:2*`PIN_RATE])
          `TL_LOW: rate_mode <= `RATE_3G;
          `TL_HIGH: rate_mode <= `RATE_6G;
          default: rate_mode <= `RATE_AUTO;
        endcase
      end
      if (register_mode) begin
        out_vod <= smb_regs[`REG_VOD][1:0];
        lane_power_down <= smb_regs[`REG_PD][5:0];
        idle_threshold <= smb_regs[`REG_IDLE];
      end else begin
        out_vod <= vod_pin;
        lane_power_down <= 6'h00;
        idle_threshold <= `IDLE_TH_DEFAULT;
      end
    end
  end

  // APB: zero-wait access, read data captured in setup
  assign pready = psel & penable;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      addr_hi <= `SMB_ADDR_HI_RST;
    end else begin
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        case (paddr)
          `APB_STATUS: if (!pwrite)
            prdata <= {26'h0, smb_busy, rate_mode, lvl_bus[2*`PIN_RATE+1:2*`PIN_RATE], register_mode};
          `APB_CTRL: if (!pwrite)
            prdata <= {29'h0, addr_hi};
          `APB_EQ: if (!pwrite)
            prdata <= {8'h0, lane_rx_eq};
          `APB_DEM: if (!pwrite)
            prdata <= {14'h0, lane_tx_deemph};
          `APB_ADDR: if (!pwrite)
            prdata <= {25'h0, slave_addr};
          `APB_MISC: if (!pwrite)
            prdata <= {16'h0, idle_threshold, lane_power_down, out_vod};
          default: pslverr <= 1'b1;
        endcase
      end
      // Upper address bits steer the SMBus slave match
      if (psel && penable && pwrite && paddr == `APB_CTRL) begin
        addr_hi <= pwdata[2:0];
      end
    end
  end

endmodule

// [sim/config_pin_mode_select_checker.sv]
`timescale 1ns/1ps
module config_pin_mode_select_checker (
  input wire core_clk,
  input wire sys_rst,
  input wire register_mode_strap,
  input wire register_mode,
  input wire [23:0] lane_rx_eq,
  input wire [17:0] lane_tx_deemph,
  input wire [1:0] rate_mode,
  input wire smb_data_oe_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Mode, pad decode and bus relations
  mode_follows_strap_a: assert property ($stable(register_mode_strap) [*4] |-> register_mode == register_mode_strap)
    else $error("mode output lags strap");
  smb_quiet_a: assert property (!register_mode [*3] |-> smb_data_oe_n)
    else $error("data pin pulled in pin mode");
  eq_pairs_a: assert property (!register_mode [*2] |-> lane_rx_eq[3:0] == lane_rx_eq[7:4] &&
    lane_rx_eq[11:8] == lane_rx_eq[15:12] && lane_rx_eq[19:16] == lane_rx_eq[23:20])
    else $error("eq group lanes differ");
  eq_codes_a: assert property (!register_mode [*2] |-> lane_rx_eq[3:0] inside {4'h1, 4'h4, 4'h8} &&
    lane_rx_eq[11:8] inside {4'h1, 4'h4, 4'h8} && lane_rx_eq[19:16] inside {4'h1, 4'h4, 4'h8})
    else $error("eq code not a pad code");
  dem_pairs_a: assert property (!register_mode [*2] |-> lane_tx_deemph[2:0] == lane_tx_deemph[5:3] &&
    lane_tx_deemph[8:6] == lane_tx_deemph[11:9] && lane_tx_deemph[14:12] == lane_tx_deemph[17:15])
    else $error("de-emphasis group lanes differ");
  dem_codes_a: assert property (!register_mode [*2] |-> lane_tx_deemph[2:0] inside {3'h0, 3'h2, 3'h5} &&
    lane_tx_deemph[8:6] inside {3'h0, 3'h2, 3'h5} && lane_tx_deemph[14:12] inside {3'h0, 3'h2, 3'h5})
    else $error("de-emphasis code not a pad code");
  rate_legal_a: assert property (rate_mode != 2'h3)
    else $error("rate mode out of range");
  unmapped_err_a: assert property (psel && !penable && !(paddr[1:0] == 2'h0 && paddr <= 8'h14) |=> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (psel && !penable && paddr == 8'h08 |=> !pslverr)
    else $error("error on mapped address");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  eq_readback_a: assert property (psel && !penable && !pwrite && paddr == 8'h08 |=> prdata[23:0] == $past(lane_rx_eq))
    else $error("eq read data differs");
endmodule
bind config_pin_mode_select config_pin_mode_select_checker i_config_pin_mode_select_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .register_mode_strap(register_mode_strap),
  .register_mode(register_mode), .lane_rx_eq(lane_rx_eq), .lane_tx_deemph(lane_tx_deemph),
  .rate_mode(rate_mode), .smb_data_oe_n(smb_data_oe_n), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .pwrite(pwrite), .prdata(prdata));

// [sim/pad_host_model.sv]
`timescale 1ns/1ps
`include "config_pin_mode_select_consts.vh"
module pad_host_model (
  input wire reg_mode,
  input wire [13:0] pad_lvl,
  input wire smb_data_oe_n,
  output reg [13:0] sense
);
  reg scl_h = 1'b1;
  reg sda_h = 1'b1;
  reg [1:0] lvl;
  integer i;
  // Open-drain data wire with pull-up
  wire sda_w = sda_h & smb_data_oe_n;
  // Two comparator senses per pad, float leaves both low
  always @* begin
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin
      lvl = pad_lvl[2*i +: 2];
      if (reg_mode && i == `PIN_SDA) lvl = sda_w ? `TL_HIGH : `TL_LOW;
      if (reg_mode && i == `PIN_SCL) lvl = scl_h ? `TL_HIGH : `TL_LOW;
      sense[2*i+1] = (lvl == `TL_HIGH);
      sense[2*i] = (lvl == `TL_LOW);
    end
  end
  // One bit slot, data set while clock low
  task bit_io(input b, output r);
    sda_h = b;
    #500 scl_h = 1'b1;
    #150 r = sda_w;
    #150 scl_h = 1'b0;
  endtask
  // Byte MSB first, then the acknowledge slot
  task byte_io(input [7:0] b, output ack);
    reg r;
    integer k;
    for (k = 7; k >= 0; k = k - 1) bit_io(b[k], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Addressed single-byte write between start and stop
  task smb_write(input [6:0] addr, input [7:0] ptr, input [7:0] d, output ok);
    reg a;
    #400 sda_h = 1'b0;
    #400 scl_h = 1'b0;
    byte_io({addr, 1'b0}, ok);
    if (ok) begin
      byte_io(ptr, a);
      byte_io(d, a);
    end
    sda_h = 1'b0;
    #500 scl_h = 1'b1;
    #300 sda_h = 1'b1;
  endtask
  // Addressed single-byte read from the current pointer, ended by a not-acknowledge
  task smb_read(input [6:0] addr, output [7:0] d, output ok);
    reg r;
    integer k;
    #400 sda_h = 1'b0;
    #400 scl_h = 1'b0;
    byte_io({addr, 1'b1}, ok);
    for (k = 7; k >= 0; k = k - 1) begin
      bit_io(1'b1, r);
      d[k] = r;
    end
    bit_io(1'b1, r);
    sda_h = 1'b0;
    #500 scl_h = 1'b1;
    #300 sda_h = 1'b1;
  endtask
endmodule

// [sim/tb_config_pin_mode_select.sv]
`timescale 1ns/1ps
`include "config_pin_mode_select_consts.vh"
module tb_config_pin_mode_select;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg register_mode_strap = 1'b0;
  reg [13:0] pad_lvl = 14'h2aaa;
  reg [1:0] vod_sel = 2'h0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  wire [13:0] sense;
  wire smb_data_oe_n, pready, pslverr, register_mode;
  wire [31:0] prdata;
  wire [23:0] lane_rx_eq;
  wire [17:0] lane_tx_deemph;
  wire [1:0] rate_mode;
  integer n_fail = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer seed = 32'h2a5c9df0;
  integer it, k;
  reg [31:0] rd;
  reg err, ok;
  reg [23:0] exp_eq;
  reg [7:0] rb;
  config_pin_mode_select i_config_pin_mode_select (.core_clk(core_clk), .sys_rst(sys_rst),
    .register_mode_strap(register_mode_strap), .port_a_rx_eq_sel_hi(sense[1]), .port_a_rx_eq_sel_lo(sense[0]),
    .port_b_rx_eq_sel_hi(sense[3]), .port_b_rx_eq_sel_lo(sense[2]), .port_d_rx_eq_sel_hi(sense[5]),
    .port_d_rx_eq_sel_lo(sense[4]), .port_a_tx_deemph_sel_hi(sense[7]), .port_a_tx_deemph_sel_lo(sense[6]),
    .port_b_tx_deemph_sel_hi(sense[9]), .port_b_tx_deemph_sel_lo(sense[8]),
    .port_d_tx_deemph_sel_hi(sense[11]), .port_d_tx_deemph_sel_lo(sense[10]), .rate_sel_hi(sense[13]),
    .rate_sel_lo(sense[12]), .vod_sel(vod_sel), .smb_data_out(), .smb_data_oe_n(smb_data_oe_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lane_rx_eq(lane_rx_eq), .lane_tx_deemph(lane_tx_deemph),
    .out_vod(), .rate_mode(rate_mode), .lane_power_down(), .idle_threshold(), .register_mode(register_mode));
  pad_host_model i_pad_host_model (.reg_mode(register_mode_strap), .pad_lvl(pad_lvl),
    .smb_data_oe_n(smb_data_oe_n), .sense(sense));
  // Clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  // Expected pad codes
  function [3:0] eqc(input [1:0] l);
    eqc = (l == `TL_LOW) ? `EQ_PIN_LOW : (l == `TL_HIGH) ? `EQ_PIN_HIGH : `EQ_PIN_FLOAT;
  endfunction
  function [2:0] demc(input [1:0] l);
    demc = (l == `TL_LOW) ? `DEM_PIN_LOW : (l == `TL_HIGH) ? `DEM_PIN_HIGH : `DEM_PIN_FLOAT;
  endfunction
  function [1:0] ratec(input [1:0] l);
    ratec = (l == `TL_LOW) ? `RATE_3G : (l == `TL_HIGH) ? `RATE_6G : `RATE_AUTO;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until ready
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(lane_rx_eq, {6{4'h4}});
    chk(lane_tx_deemph, {6{3'h2}});
    chk(smb_data_oe_n, 1'b1);
    $display("reset test done");
    for (it = 0; it < 12; it = it + 1) begin
      @(posedge core_clk);
      if (it < 2) pad_lvl <= it ? 14'h1555 : 14'h0;
      else for (k = 0; k < 7; k = k + 1) pad_lvl[2*k +: 2] <= 2'($unsigned($random(seed)) % 3);
      vod_sel <= 2'($random(seed));
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      exp_eq = {{2{eqc(pad_lvl[5:4])}}, {2{eqc(pad_lvl[3:2])}}, {2{eqc(pad_lvl[1:0])}}};
      chk(lane_rx_eq, exp_eq);
      chk(lane_tx_deemph, {{2{demc(pad_lvl[11:10])}}, {2{demc(pad_lvl[9:8])}}, {2{demc(pad_lvl[7:6])}}});
      chk(rate_mode, ratec(pad_lvl[13:12]));
      apb(1'b1, `APB_EQ, 32'hffffffff);
      apb(1'b0, `APB_EQ, 32'h0);
      chk({err, rd[23:0]}, exp_eq);
      apb(1'b0, `APB_STATUS, 32'h0);
      chk(rd[4:0], {ratec(pad_lvl[13:12]), pad_lvl[13:12], 1'b0});
      apb(1'b0, `APB_MISC, 32'h0);
      chk(rd[15:0], {`IDLE_TH_DEFAULT, 6'h00, vod_sel});
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `APB_CTRL, 32'h3);
    $display("pin mode test done");
    @(posedge core_clk);
    register_mode_strap <= 1'b1;
    pad_lvl <= {`TL_LOW, `TL_LOW, `TL_FLOAT, `TL_LOW, `TL_HIGH, `TL_FLOAT, `TL_HIGH};
    repeat (10) @(posedge core_clk);
    apb(1'b0, `APB_ADDR, 32'h0);
    chk(rd[6:0], 7'h35);
    apb(1'b0, `APB_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    chk(rate_mode, `RATE_3G);
    i_pad_host_model.smb_write(7'h36, 8'h01, 8'h0c, ok);
    chk(ok, 1'b0);
    i_pad_host_model.smb_write(7'h35, 8'h00, 8'h0f, ok);
    chk(ok, 1'b1);
    i_pad_host_model.smb_write(7'h35, 8'h06, 8'h07, ok);
    i_pad_host_model.smb_write(7'h35, 8'h0d, 8'h01, ok);
    i_pad_host_model.smb_write(7'h35, 8'h0f, 8'h5a, ok);
    i_pad_host_model.smb_read(7'h35, rb, ok);
    chk(rb, 8'h0f);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(rate_mode, `RATE_6G);
    apb(1'b0, `APB_MISC, 32'h0);
    chk(rd[15:8], 8'h5a);
    chk(lane_rx_eq, 24'h44444f);
    chk(lane_rx_eq[7:4], 4'h4);
    chk(lane_tx_deemph, {{5{3'h2}}, 3'h7});
    $display("register mode test done");
    @(posedge core_clk);
    register_mode_strap <= 1'b0;
    i_pad_host_model.smb_write(7'h35, 8'h00, 8'h01, ok);
    chk(ok, 1'b0);
    chk(lane_rx_eq, {{2{4'h8}}, {2{4'h4}}, {2{4'h8}}});
    chk(rate_mode, `RATE_3G);
    $display("return test done");
    report_and_stop;
  end
endmodule
